// ### core/tiv_top.sv
// interrupt routing, priority and vectoring around the interval timer
// Notes on behaviour
// R01: timer counter is fourteen bits, loaded by software with a count length.
// R02: four timer functions, chosen by a software command before or during operation.
// R03: timer count readable at any moment without disturbing the count.
// R04: pulse function drives low only in second half; software loads double width.
// R05: square wave high first half, low second half, reloads at terminal count.
// R06: rate generator divides by count, low pulse and restart at terminal count.
// R07: strobe function gives exactly one low pulse at terminal count.
// R08: timer completion raises the middle-upper maskable request.
// R09: priority: non-maskable, then high, middle, low maskable levels.
// R10: vectors: non-maskable 26, high 3C, middle 34, low 2C.
// R11: three leveled inputs maskable by software; top input never maskable.
// R12: ports one and two raise requests when in latched-and-strobed operation.
// R13: user input wired directly to the non-maskable input.
// R14: outside system should use non-maskable input only for catastrophic events.
// R15: outside request lines are active low.
// R16: only the highest pending unmasked request is presented; others stay pending.
// R17: masked requests wait and are presented once unmasked while still active.
`timescale 1ns/1ps
`default_nettype none
`include "tiv_defines.svh"
module tiv_top #(
	parameter int CNT_W = `TIV_CNT_W
) (
	input wire logic clk_i, // system clock, 25 MHz
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic fail_n_i, // user catastrophic-error request pin, active low
	input wire logic port1_stb_n_i, // port one strobe pin, active low
	input wire logic port2_stb_n_i, // port two strobe pin, active low
	input wire logic port1_latched_i, // port one set for latched-and-strobed operation
	input wire logic port2_latched_i, // port two set for latched-and-strobed operation
	input wire logic tmr_load_i, // pulse: load length and function, start timer
	input wire logic tmr_stop_i, // pulse: stop timer
	input wire logic [1:0] tmr_mode_i, // timer function select
	input wire logic [CNT_W-1:0] tmr_len_i, // count length
	input wire logic [2:0] mask_wr_i, // pulse per bit: write mask for high, middle, low
	input wire logic [2:0] mask_i, // new mask bits, 1 masks the level
	input wire logic ack_i, // pulse: processor accepts presented vector
	output logic irq_o, // request presented to processor
	output logic [7:0] vec_o, // vector address of presented request
	output logic [CNT_W-1:0] tmr_count_o, // live timer count
	output logic tmr_out_n_o, // timer output, active low
	output logic [3:0] pend_o, // pending: nmi, high, middle, low
	output logic [2:0] mask_o // present mask bits
);
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic [3:0] pend;
		logic [2:0] mask;
		logic irq;
		logic [7:0] vec;
		logic [CNT_W-1:0] count;
		logic out_n;
	} tiv_top_state_t;
	tiv_top_state_t s_reg, s_next;
	tiv_pkg::tiv_tmr_cmd_t tcmd;
	tiv_pkg::tiv_tmr_stat_t tstat;
	logic [2:0] fall;
	logic [3:0] set;
	logic [3:0] live;
	logic [3:0] clr;
	always_comb begin
		tcmd.load = tmr_load_i;
		tcmd.stop = tmr_stop_i;
		tcmd.mode = tmr_mode_i; // R02
		tcmd.length = tmr_len_i; // R01
	end
	tiv_timer #(.CNT_W(CNT_W)) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.cmd_i(tcmd),
		.stat_o(tstat)
	);
	always_comb begin
		s_next = s_reg;
		// pins inverted once here, active low outside
		s_next.sync1 = {~fail_n_i, ~port1_stb_n_i, ~port2_stb_n_i}; // R15
		s_next.sync2 = s_reg.sync1;
		s_next.prev = s_reg.sync2;
		fall = s_reg.sync2 & ~s_reg.prev;
		set = 4'h0;
		set[3] = fall[2]; // R13
		set[2] = 1'b0;
		set[1] = tstat.done; // R08
		set[0] = (fall[1] & port1_latched_i) | (fall[0] & port2_latched_i); // R12
		for (int i = 0; i < 3; i++) begin
			if (mask_wr_i[i]) begin
				s_next.mask[i] = mask_i[i]; // R11
			end
		end
		live = s_reg.pend & {1'b1, ~s_reg.mask}; // R11 R17
		clr = 4'h0;
		if (ack_i && s_reg.irq) begin
			case (s_reg.vec)
				`TIV_VEC_NMI: clr = 4'h8;
				`TIV_VEC_HIGH: clr = 4'h4;
				`TIV_VEC_MID: clr = 4'h2;
				`TIV_VEC_LOW: clr = 4'h1;
				default: clr = 4'h0;
			endcase
		end
		// a new event in the ack cycle survives the clear
		s_next.pend = (s_reg.pend & ~clr) | set; // R16
		s_next.irq = |(live & ~clr);
		if (live[3] && !clr[3]) begin
			s_next.vec = `TIV_VEC_NMI; // R09 R10
		end else if (live[2] && !clr[2]) begin
			s_next.vec = `TIV_VEC_HIGH; // R09 R10
		end else if (live[1] && !clr[1]) begin
			s_next.vec = `TIV_VEC_MID; // R09 R10
		end else if (live[0] && !clr[0]) begin
			s_next.vec = `TIV_VEC_LOW; // R09 R10
		end else begin
			s_next.vec = `TIV_VEC_NONE;
		end
		s_next.count = tstat.count; // R03
		s_next.out_n = tstat.out_n;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '{sync1: 3'h0, sync2: 3'h0, prev: 3'h0, pend: 4'h0, mask: `TIV_MASK_RST,
				irq: 1'b0, vec: `TIV_VEC_NONE, count: '0, out_n: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end
	assign irq_o = s_reg.irq;
	assign vec_o = s_reg.vec;
	assign tmr_count_o = s_reg.count;
	assign tmr_out_n_o = s_reg.out_n;
	assign pend_o = s_reg.pend;
	assign mask_o = s_reg.mask;
endmodule : tiv_top
`default_nettype wire

// ### core/tiv_defines.svh
// constants for the timer and interrupt vectoring block
`ifndef TIV_DEFINES_SVH
`define TIV_DEFINES_SVH
`define TIV_CNT_W 14
`define TIV_VEC_NMI 8'h26
`define TIV_VEC_HIGH 8'h3C
`define TIV_VEC_MID 8'h34
`define TIV_VEC_LOW 8'h2C
`define TIV_VEC_NONE 8'h00
`define TIV_MODE_PULSE 2'h0
`define TIV_MODE_SQUARE 2'h1
`define TIV_MODE_RATE 2'h2
`define TIV_MODE_STROBE 2'h3
`define TIV_MASK_RST 3'h7
`define TIV_LEN_RST 14'h0000
`define TIV_MIN_LEN 14'h0002
`endif

// ### core/tiv_pkg.sv
// types for the timer and interrupt vectoring block
package tiv_pkg;
	typedef enum logic [3:0] {
		TIV_ST_IDLE = 4'h1,
		TIV_ST_RUN = 4'h2,
		TIV_ST_DONE = 4'h4,
		TIV_ST_ACK = 4'h8
	} tiv_state_t;
	typedef struct packed {
		logic load;
		logic [1:0] mode;
		logic [13:0] length;
		logic stop;
	} tiv_tmr_cmd_t;
	typedef struct packed {
		logic [13:0] count;
		logic out_n;
		logic done;
		logic running;
	} tiv_tmr_stat_t;
endpackage : tiv_pkg

// ### core/tiv_timer.sv
// 14-bit interval timer with four output functions
`timescale 1ns/1ps
`default_nettype none
`include "tiv_defines.svh"
module tiv_timer #(
	parameter int CNT_W = `TIV_CNT_W
) (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire tiv_pkg::tiv_tmr_cmd_t cmd_i, // load or stop command
	output var tiv_pkg::tiv_tmr_stat_t stat_o // count, output and completion pulse
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] len;
		logic [1:0] mode;
		logic run;
		logic out_n;
		logic done;
	} tiv_tmr_state_t;
	tiv_tmr_state_t s_reg, s_next;
	logic [CNT_W-1:0] half;
	logic tc;
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		half = s_reg.len >> 1;
		tc = (s_reg.cnt <= {{(CNT_W-1){1'b0}}, 1'b1});
		if (cmd_i.stop) begin
			s_next.run = 1'b0;
			s_next.out_n = 1'b1;
		end else if (cmd_i.load) begin
			s_next.len = (cmd_i.length < `TIV_MIN_LEN) ? `TIV_MIN_LEN : cmd_i.length; // R01
			s_next.cnt = s_next.len;
			s_next.mode = cmd_i.mode; // R02
			s_next.run = 1'b1;
			s_next.out_n = 1'b1;
		end else if (s_reg.run) begin
			if (tc) begin
				s_next.done = 1'b1;
				case (s_reg.mode)
					`TIV_MODE_PULSE: begin
						s_next.run = 1'b0;
						s_next.out_n = 1'b1;
					end
					`TIV_MODE_SQUARE: begin
						s_next.cnt = s_reg.len; // R05
						s_next.out_n = 1'b1;
					end
					`TIV_MODE_RATE: begin
						s_next.cnt = s_reg.len; // R06
						s_next.out_n = 1'b0;
					end
					`TIV_MODE_STROBE: begin
						s_next.run = 1'b0; // R07
						s_next.out_n = 1'b0;
					end
					default: s_next.run = 1'b0;
				endcase
			end else begin
				s_next.cnt = s_reg.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
				case (s_reg.mode)
					`TIV_MODE_PULSE, `TIV_MODE_SQUARE: s_next.out_n = (s_next.cnt > half); // R04 R05
					default: s_next.out_n = 1'b1;
				endcase
			end
		end else begin
			// one-clock low strobe ends here
			s_next.out_n = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '{cnt: '0, len: `TIV_LEN_RST, mode: `TIV_MODE_PULSE, run: 1'b0, out_n: 1'b1, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end
	// count is read straight from the running register, so a read never disturbs it
	assign stat_o = '{count: s_reg.cnt, out_n: s_reg.out_n, done: s_reg.done, running: s_reg.run}; // R03
endmodule : tiv_timer
`default_nettype wire

// ### test/tiv_top_sva.sv
// assertions on the vectoring block's ports
`timescale 1ns/1ps
`default_nettype none
module tiv_top_sva #(
	parameter int CNT_W = 14
) (
	input wire logic clk_i, // clk
	input wire logic rst_n_i, // rst
	input wire logic fail_n_i, // pin
	input wire logic port1_stb_n_i, // pin
	input wire logic port1_latched_i, // mode
	input wire logic ack_i, // ack
	input wire logic irq_o, // irq
	input wire logic [7:0] vec_o, // vec
	input wire logic [3:0] pend_o, // pend
	input wire logic [2:0] mask_o // mask
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_lo; pend_o == 4'h1 && !mask_o[0] && !ack_i; endsequence
	property p_lo; s_lo |=> irq_o && vec_o == 8'h2C; endproperty
	a_lo: assert property (p_lo) else $error("low vector");
	property p_nm; pend_o[3] && !ack_i |=> irq_o && vec_o == 8'h26; endproperty
	a_nm: assert property (p_nm) else $error("trap vector");
	property p_md; pend_o[1] && !pend_o[3] && !mask_o[1] && !ack_i |=> vec_o == 8'h34; endproperty
	a_md: assert property (p_md) else $error("mid vector");
	property p_qt; !pend_o[3] && !(pend_o[1] && !mask_o[1]) && !(pend_o[0] && !mask_o[0]) |=> !irq_o; endproperty
	a_qt: assert property (p_qt) else $error("masked shown");
	property p_iv; irq_o |-> vec_o != 8'h00; endproperty
	a_iv: assert property (p_iv) else $error("no vector");
	property p_tr; $fell(fail_n_i) |-> ##[1:6] pend_o[3]; endproperty
	a_tr: assert property (p_tr) else $error("trap lost");
	property p_pt; $fell(port1_stb_n_i) && port1_latched_i |-> ##[1:6] pend_o[0]; endproperty
	a_pt: assert property (p_pt) else $error("port lost");
	property p_ak; irq_o && vec_o == 8'h2C && ack_i |=> !pend_o[0]; endproperty
	a_ak: assert property (p_ak) else $error("ack kept");
endmodule : tiv_top_sva
bind tiv_top tiv_top_sva #(.CNT_W(CNT_W)) u_sva (.clk_i, .rst_n_i, .fail_n_i, .port1_stb_n_i, .port1_latched_i,
	.ack_i, .irq_o, .vec_o, .pend_o, .mask_o);
`default_nettype wire

// ### test/tiv_cpu_model.sv
// processor core model that takes presented vectors
`timescale 1ns/1ps
`default_nettype none
module tiv_cpu_model (
	input wire logic clk_i, // clk
	input wire logic rst_n_i, // rst
	input wire logic irq_i, // request
	input wire logic slow_i, // long wait
	output logic ack_o // take
);
	logic [3:0] wait_reg;
	// at least three cycles, so a request already cleared is never taken twice
	always_ff @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (!rst_n_i || !irq_i || ack_o) begin
			wait_reg <= 4'h0;
		end else if (wait_reg == (slow_i ? 4'h9 : 4'h3)) begin
			ack_o <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : tiv_cpu_model
`default_nettype wire

// ### test/tiv_top_tb_top.sv
// bench: pin stimulus, core model and vector scoreboard
`timescale 1ns/1ps
`default_nettype none
module tiv_top_tb_top;
	logic clk_i = 0, rst_n_i = 0, fl = 1, s1 = 1, s2 = 1, l1 = 0, l2 = 0, ld = 0, stp = 0, slow = 0, ack, irq, tout;
	logic [1:0] md = 0;
	logic [2:0] mwr = 0, msk = 0, mo;
	logic [3:0] pend;
	logic [7:0] vec, q[$];
	logic [13:0] len = 0, cnt;
	int err_total = 0, n_tests = 0, seed = 32'hc17e34a3, lows = 0;
	always #20 clk_i = ~clk_i;
	tiv_top DUT (.clk_i, .rst_n_i, .fail_n_i(fl), .port1_stb_n_i(s1), .port2_stb_n_i(s2), .port1_latched_i(l1),
		.port2_latched_i(l2), .tmr_load_i(ld), .tmr_stop_i(stp), .tmr_mode_i(md), .tmr_len_i(len), .mask_wr_i(mwr),
		.mask_i(msk), .ack_i(ack), .irq_o(irq), .vec_o(vec), .tmr_count_o(cnt), .tmr_out_n_o(tout), .pend_o(pend),
		.mask_o(mo));
	tiv_cpu_model cpu (.clk_i, .rst_n_i, .irq_i(irq), .slow_i(slow), .ack_o(ack));
	task chk(input string nm, input logic [13:0] e, g);
		n_tests++;
		if (e !== g) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task wmask(input logic [2:0] m);
		@(posedge clk_i);
		mwr <= 3'h7;
		msk <= m;
		@(posedge clk_i);
		mwr <= 3'h0;
	endtask : wmask
	task summarize;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	// sampled mid-cycle so registered outputs have settled
	always @(negedge clk_i) begin
		if (!tout) lows++;
		if (ack) chk("vec", q.size() ? q.pop_front() : 8'hFF, vec);
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		tick(1);
		chk("mask", 3'h7, mo);
		@(posedge clk_i);
		l1 <= 1'b1;
		s1 <= 1'b0;
		s2 <= 1'b0;
		tick(10);
		chk("pend", 4'h1, pend);
		chk("irq", 1'b0, irq);
		q.push_back(8'h2C);
		wmask(3'h0);
		tick(12);
		chk("mask", 3'h0, mo);
		@(posedge clk_i);
		s1 <= 1'b1;
		s2 <= 1'b1;
		l2 <= 1'b1;
		slow <= 1'b1;
		wmask(3'h7);
		q.push_back(8'h26);
		@(posedge clk_i);
		fl <= 1'b0;
		s2 <= 1'b0;
		md <= 2'h3;
		len <= 14'h2;
		ld <= 1'b1;
		@(posedge clk_i);
		ld <= 1'b0;
		tick(40);
		chk("pend", 4'h3, pend);
		q.push_back(8'h34);
		q.push_back(8'h2C);
		wmask(3'h0);
		tick(60);
		chk("pend", 4'h0, pend);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i);
			fl <= 1'b1;
			s2 <= 1'b1;
			slow <= m[0];
			md <= m[1:0];
			len <= 14'h40 + 14'($random(seed) & 63);
			ld <= 1'b1;
			q.push_back(8'h34);
			@(posedge clk_i);
			ld <= 1'b0;
			lows = 0;
			tick(10);
			chk("cnt", len - 14'h9, cnt);
			chk("out", 1'b1, tout);
			repeat (3000) begin
				@(negedge clk_i);
				if (ack) break;
			end
			if (m == 3) tick(200);
			@(posedge clk_i);
			stp <= 1'b1;
			@(posedge clk_i);
			stp <= 1'b0;
			tick(4);
			chk("out", 1'b1, tout);
			chk("low", m < 2 ? len >> 1 : 14'h1, 14'(lows));
		end
		chk("left", 14'h0, 14'(q.size()));
		summarize;
	end
	initial begin
		#800000;
		err_total++;
		summarize;
	end
endmodule : tiv_top_tb_top
`default_nettype wire
